/* rtl/tp_timing_cfg.svh */
`ifndef TP_TIMING_CFG_SVH
`define TP_TIMING_CFG_SVH
// Register byte offsets
`define TP_OFF_CTRL     12'h000
`define TP_OFF_PAR0     12'h004
`define TP_OFF_PAR1     12'h008
`define TP_OFF_PAR2     12'h00c
`define TP_OFF_PAR3     12'h010
`define TP_OFF_DEST     12'h014
`define TP_OFF_EVT      12'h018
`define TP_OFF_STAT     12'h01c
`define TP_OFF_TPVAL    12'h020
`define TP_OFF_RHDVAL   12'h024
`define TP_OFF_ACKSET   12'h028
`define TP_OFF_DLIST    12'h02c
// Control fields
`define TP_CTRL_ENABLE  0
`define TP_CTRL_IMMRTX  1
`define TP_CTRL_RENAD   2
`define TP_CTRL_MAXTX_LSB 4
// Event command codes written to EVT
`define TP_EVT_TX_ACKREQ   4'h1
`define TP_EVT_TX_PLAIN    4'h2
`define TP_EVT_RX_T3       4'h3
`define TP_EVT_RX_T124     4'h4
`define TP_EVT_RX_ACK      4'h5
`define TP_EVT_RX_ACK_UNEX 4'h6
`define TP_EVT_RX_PLAIN    4'h7
`define TP_EVT_CLEAR       4'h0
`define TP_EVT_TX_QUEUE    4'h8
// Tick = 100 ns (tenth of a microsecond) at 100 MHz
`define TP_TICK_NS      100
`define TP_CLK_NS       10
`define TP_TICK_CYC     (`TP_TICK_NS / `TP_CLK_NS)
`define TP_ACK_MULT     5'd15
`define TP_SPECIAL3     8'h03
`define TP_MAXTX_RST    4'h3
`define TP_DEST_N       16
`endif

/* rtl/tp_timing_pkg.sv */
package tp_timing_pkg;
    typedef struct packed {
        logic [15:0] epre;
        logic [15:0] phasing;
        logic [15:0] s;
        logic [15:0] elag;
        logic [15:0] turn;
        logic [15:0] tol;
        logic [15:0] dteack;
        logic [15:0] dteproc;
    } tp_par_t;
    typedef struct packed {
        logic        tp_run;
        logic        nad_ok;
        logic        rtx_req;
        logic        resp_pend;
        logic        tx_done_max;
    } tp_stat_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ELAG = 4'b0010,
        ST_TP   = 4'b0100,
        ST_DONE = 4'b1000
    } tp_state_t;
endpackage

/* rtl/tp_dest_mem.sv */
`timescale 1ns/1ps
// Destination address list, registered read
module tp_dest_mem (
    // Clock
    input  wire logic       clk,
    input  wire logic       ce,
    // Write
    input  wire logic       we,
    input  wire logic [3:0] waddr,
    input  wire logic [7:0] wdata,
    // Read
    input  wire logic [3:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:15];
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule

/* rtl/tp_delay_calc.sv */
`timescale 1ns/1ps
`include "tp_timing_cfg.svh"
// Delay arithmetic in ticks; one register stage
module tp_delay_calc (
    // Clock
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // Parameters and counts
    input  wire tp_timing_pkg::tp_par_t par,
    input  wire logic            [4:0] j_cnt,
    input  wire logic            [4:0] pos_i,
    // Results
    output logic                [23:0] rhd0,
    output logic                [23:0] tp_ack,
    output logic                [23:0] tp_plain,
    output logic                [23:0] tp_unexp,
    output logic                [23:0] rhd_i
);
    function automatic logic [23:0] max16(input logic [15:0] a, input logic [15:0] b);
        max16 = (a > b) ? {8'h00, a} : {8'h00, b};
    endfunction
    function automatic logic [23:0] mul(input logic [4:0] n, input logic [23:0] v);
        logic [28:0] p;
        p = n * v;
        mul = p[23:0];
    endfunction
    logic [23:0] base;
    always_comb begin
        base = 24'(par.epre) + 24'(par.phasing) + 24'(par.s) + 24'(par.elag)
             + 24'(par.turn) + 24'(par.tol);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rhd0     <= 24'h000000;
            tp_ack   <= 24'h000000;
            tp_plain <= 24'h000000;
            tp_unexp <= 24'h000000;
            rhd_i    <= 24'h000000;
        end else if (ce) begin
            rhd0     <= base;
            tp_ack   <= mul(j_cnt, base) + 24'(par.tol) + max16(par.dteack, par.turn);
            tp_plain <= max16(par.dteproc, par.turn) + 24'(par.tol);
            tp_unexp <= mul(`TP_ACK_MULT, base) + 24'(par.tol) + 24'(par.turn);
            rhd_i    <= mul(5'(pos_i - 5'd1), base) + max16(par.dteack, par.turn)
                      + 24'(par.tol);
        end
    end
endmodule

/* rtl/tp_timing_ctrl.sv */
`timescale 1ns/1ps
`include "tp_timing_cfg.svh"
// Behaviour
// - Access slot waits for timeout end
// - Shared timeout parameters except immediate retransmit
// - Receivers count individual and special 1,2,3
// - Timeout counting starts at end of ELAG
// - Still process Type 1, 2, 4 frames
// - Unexpected frames never pause timers
// - Defer new responses until timeout ends
// - New Type 3 frame restarts timeout procedure
// - Plain data timeout max(DTEPROC,TURN)+TOL unless RE-NAD
// - On acknowledgment check timeout running
// - Else start 15RHD0+TOL+TURN at last bit
// - Non-acknowledgment sends wait for next slot
// - RHD0 is EPRE+PHASING+S+ELAG+TURN+TOL
// - Acked timeout j*RHD0+TOL+max(DTEACK,TURN)
module tp_timing_ctrl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link side events
    input  wire logic        elag_end,
    input  wire logic        ack_rx,
    input  wire logic [3:0]  ack_idx,
    input  wire logic        nad_slot,
    // Station controls
    output logic             tp_active,
    output logic             tx_go,
    output logic             rtx_req,
    output logic             resp_go,
    output logic             frame_proc
);
    tp_timing_pkg::tp_par_t   par_r;
    tp_timing_pkg::tp_state_t st_r;
    logic [7:0]  ctrl_r;
    logic [15:0] dest_valid_r;
    logic [15:0] acked_r;
    logic [3:0]  dest_cnt_r;
    logic [4:0]  pos_i_r;
    logic [3:0]  txcnt_r;
    logic [23:0] tp_cnt_r;
    logic [23:0] tp_load_r;
    logic [3:0]  tick_r;
    logic        await_ack_r;
    logic        resp_pend_r;
    logic        tx_pend_r;
    logic        expired_r;
    logic [4:0]  j_cnt;
    logic [23:0] rhd0;
    logic [23:0] tp_ack;
    logic [23:0] tp_plain;
    logic [23:0] tp_unexp;
    logic [23:0] rhd_i;
    logic [7:0]  mem_rdata;
    logic [3:0]  mem_raddr_r;
    logic        wr;
    logic        rd;
    logic        evt_wr;
    logic [3:0]  evt;
    logic        tick;
    logic        all_acked;
    logic        evt_clear;
    logic        evt_queue;
    logic        evt_t124;
    tp_timing_pkg::tp_stat_t stat;

    // Zero wait state slave
    assign wr     = psel && penable && pwrite;
    assign rd     = psel && !penable && !pwrite;
    assign evt_wr = wr && (paddr == `TP_OFF_EVT);
    assign evt    = pwdata[3:0];
    assign tick   = (tick_r == 4'(`TP_TICK_CYC - 1));
    assign all_acked = ((acked_r | ~dest_valid_r) == 16'hffff);

    // One decode for the clear, queue and Type 1,2,4 strobes; a wrong code stays in one place
    function automatic logic is_evt(input logic s, input logic [3:0] c, input logic [3:0] k);
        is_evt = s && (c == k);
    endfunction

    assign evt_clear = is_evt(evt_wr, evt, `TP_EVT_CLEAR);
    assign evt_queue = is_evt(evt_wr, evt, `TP_EVT_TX_QUEUE);
    assign evt_t124  = is_evt(evt_wr, evt, `TP_EVT_RX_T124);

    // Sender count: special 3 never counted; 1,2 always
    always_comb begin
        j_cnt = 5'(dest_cnt_r);
    end

    tp_dest_mem u_mem (
        .clk   (clk),
        .ce    (ce),
        .we    (wr && paddr == `TP_OFF_DLIST),
        .waddr (pwdata[11:8]),
        .wdata (pwdata[7:0]),
        .raddr (mem_raddr_r),
        .rdata (mem_rdata)
    );

    tp_delay_calc u_calc (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .par      (par_r),
        .j_cnt    (j_cnt),
        .pos_i    (pos_i_r),
        .rhd0     (rhd0),
        .tp_ack   (tp_ack),
        .tp_plain (tp_plain),
        .tp_unexp (tp_unexp),
        .rhd_i    (rhd_i)
    );

    // Parameter and control registers; one set per subnet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r  <= {`TP_MAXTX_RST, 4'h1};
            par_r   <= '0;
            pos_i_r <= 5'd1;
        end else if (ce && wr) begin
            case (paddr)
                `TP_OFF_CTRL: ctrl_r <= pwdata[7:0];
                `TP_OFF_PAR0: {par_r.epre, par_r.phasing} <= pwdata;
                `TP_OFF_PAR1: {par_r.s, par_r.elag} <= pwdata;
                `TP_OFF_PAR2: {par_r.turn, par_r.tol} <= pwdata;
                `TP_OFF_PAR3: {par_r.dteack, par_r.dteproc} <= pwdata;
                `TP_OFF_DEST: pos_i_r <= pwdata[4:0];
                default: ;
            endcase
        end
    end

    // Destination list: sender excludes special address 3
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dest_valid_r <= 16'h0000;
            dest_cnt_r   <= 4'h0;
        end else if (ce && wr && paddr == `TP_OFF_DLIST) begin
            if (pwdata[7:0] == `TP_SPECIAL3 && !pwdata[16]) begin
                dest_valid_r[pwdata[11:8]] <= 1'b0;
            end else begin
                dest_valid_r[pwdata[11:8]] <= 1'b1;
                dest_cnt_r <= dest_cnt_r + 4'h1;
            end
        // Count wraps if all sixteen slots are used
        end else if (ce && evt_clear) begin
            dest_valid_r <= 16'h0000;
            dest_cnt_r   <= 4'h0;
        end
    end

    // Acknowledgment bookkeeping; pruned list before retransmit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acked_r <= 16'h0000;
        end else if (ce) begin
            // Late acknowledgments after the run are ignored
            if (ack_rx && await_ack_r) begin
                acked_r[ack_idx] <= 1'b1;
            end else if (evt_clear) begin
                acked_r <= 16'h0000;
            end
        end
    end

    // Free-running tick; a run may end up to one tick early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_r <= 4'h0;
        end else if (ce) begin
            tick_r <= tick ? 4'h0 : tick_r + 4'h1;
        end
    end

    // Timeout procedure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r        <= tp_timing_pkg::ST_IDLE;
            tp_cnt_r    <= 24'h000000;
            tp_load_r   <= 24'h000000;
            await_ack_r <= 1'b0;
            expired_r   <= 1'b0;
        end else if (ce) begin
            expired_r <= 1'b0;
            if (ce && evt_wr && (evt == `TP_EVT_TX_ACKREQ || evt == `TP_EVT_RX_T3)) begin
                st_r        <= tp_timing_pkg::ST_ELAG;
                tp_load_r   <= tp_ack;
                await_ack_r <= (evt == `TP_EVT_TX_ACKREQ);
            end else if (evt_wr && evt == `TP_EVT_RX_ACK_UNEX) begin
                st_r      <= tp_timing_pkg::ST_TP;
                tp_cnt_r  <= tp_unexp;
                await_ack_r <= 1'b0;
            end else if (evt_wr && evt == `TP_EVT_RX_ACK
                         && st_r == tp_timing_pkg::ST_IDLE) begin
                st_r     <= tp_timing_pkg::ST_TP;
                tp_cnt_r <= tp_unexp;
            end else if (evt_wr && !ctrl_r[`TP_CTRL_RENAD]
                         && (evt == `TP_EVT_TX_PLAIN || evt == `TP_EVT_RX_PLAIN)
                         && st_r == tp_timing_pkg::ST_IDLE) begin
                st_r      <= tp_timing_pkg::ST_ELAG;
                tp_load_r <= tp_plain;
            end else begin
                case (st_r)
                    tp_timing_pkg::ST_IDLE: ;
                    tp_timing_pkg::ST_ELAG: begin
                        if (elag_end) begin
                            st_r     <= tp_timing_pkg::ST_TP;
                            tp_cnt_r <= tp_load_r;
                        end
                    end
                    tp_timing_pkg::ST_TP: begin
                        if (await_ack_r && all_acked) begin
                            st_r <= tp_timing_pkg::ST_DONE;
                        end else if (tp_cnt_r == 24'h000000) begin
                            st_r      <= tp_timing_pkg::ST_DONE;
                            expired_r <= await_ack_r;
                        end else if (tick) begin
                            tp_cnt_r <= tp_cnt_r - 24'h000001;
                        end
                    end
                    tp_timing_pkg::ST_DONE: begin
                        st_r        <= tp_timing_pkg::ST_IDLE;
                        await_ack_r <= 1'b0;
                    end
                    default: st_r <= tp_timing_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Transmission count and retransmit request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txcnt_r <= 4'h0;
            rtx_req <= 1'b0;
        end else if (ce) begin
            if (evt_wr && evt == `TP_EVT_TX_ACKREQ) begin
                txcnt_r <= txcnt_r + 4'h1;
                rtx_req <= 1'b0;
            end else if (evt_clear) begin
                txcnt_r <= 4'h0;
                rtx_req <= 1'b0;
            end else if (expired_r && txcnt_r < ctrl_r[7:4]) begin
                rtx_req <= 1'b1;
            end
        end
    end

    // Deferred response and queued transmit; transmit slot gated
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_pend_r <= 1'b0;
            tx_pend_r   <= 1'b0;
            resp_go     <= 1'b0;
            tx_go       <= 1'b0;
            frame_proc  <= 1'b0;
            tp_active   <= 1'b0;
        end else if (ce) begin
            // Done counts as over, so launch and retransmit never overlap a run
            tp_active  <= (st_r != tp_timing_pkg::ST_IDLE) && (st_r != tp_timing_pkg::ST_DONE);
            frame_proc <= evt_t124;
            resp_go    <= 1'b0;
            tx_go      <= 1'b0;
            if (evt_t124) begin
                resp_pend_r <= 1'b1;
            end else if (resp_pend_r && st_r == tp_timing_pkg::ST_IDLE) begin
                resp_pend_r <= 1'b0;
                resp_go     <= 1'b1;
            end
            if (evt_queue) begin
                tx_pend_r <= 1'b1;
            end else if (tx_pend_r && st_r == tp_timing_pkg::ST_IDLE
                         && nad_slot && ctrl_r[`TP_CTRL_ENABLE]) begin
                tx_pend_r <= 1'b0;
                tx_go     <= 1'b1;
            end
        end
    end

    // Status summary; upper bits of the status word
    always_comb begin
        stat.tp_run      = (st_r != tp_timing_pkg::ST_IDLE);
        stat.nad_ok      = tx_pend_r && (st_r == tp_timing_pkg::ST_IDLE);
        stat.rtx_req     = rtx_req;
        stat.resp_pend   = resp_pend_r;
        stat.tx_done_max = (txcnt_r >= ctrl_r[7:4]);
    end

    // Read data; prepared in setup phase
    // Unmapped writes are dropped silently; reads flag an error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            mem_raddr_r <= 4'h0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (rd) begin
                case (paddr)
                    `TP_OFF_CTRL:   prdata <= {24'h000000, ctrl_r};
                    `TP_OFF_PAR0:   prdata <= {par_r.epre, par_r.phasing};
                    `TP_OFF_PAR1:   prdata <= {par_r.s, par_r.elag};
                    `TP_OFF_PAR2:   prdata <= {par_r.turn, par_r.tol};
                    `TP_OFF_PAR3:   prdata <= {par_r.dteack, par_r.dteproc};
                    `TP_OFF_DEST:   prdata <= {27'h0000000, pos_i_r};
                    `TP_OFF_STAT:   prdata <= {15'h0000, stat, txcnt_r, st_r, rtx_req,
                                              resp_pend_r, tx_pend_r, await_ack_r};
                    `TP_OFF_TPVAL:  prdata <= {8'h00, tp_cnt_r};
                    `TP_OFF_RHDVAL: prdata <= {8'h00, rhd_i};
                    `TP_OFF_ACKSET: prdata <= {dest_valid_r, acked_r};
                    `TP_OFF_DLIST:  prdata <= {24'h000000, mem_rdata};
                    default: begin
                        prdata  <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (wr && paddr == `TP_OFF_DEST) begin
                mem_raddr_r <= pwdata[11:8];
            end
        end
    end
endmodule

/* test/tp_timing_monitor.sv */
`timescale 1ns/1ps
module tp_timing_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus answer
    input wire logic pready,
    // Link and station controls
    input wire logic elag_end,
    input wire logic nad_slot,
    input wire logic tp_active,
    input wire logic tx_go,
    input wire logic rtx_req,
    input wire logic resp_go,
    input wire logic frame_proc
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Cycles of the current timeout run
    logic [15:0] run_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= 16'h0000;
        end else begin
            run_r <= tp_active ? run_r + 16'h0001 : 16'h0000;
        end
    end
    a_go_after_tp: assert property (tx_go |-> !tp_active)
        else $error("launch while timeout runs");
    a_go_on_slot: assert property (tx_go |-> $past(nad_slot))
        else $error("launch off a slot start");
    a_go_single: assert property (tx_go |=> !tx_go)
        else $error("launch pulse too long");
    a_resp_deferred: assert property (resp_go |-> !tp_active)
        else $error("response during timeout");
    a_resp_single: assert property (resp_go |=> !resp_go)
        else $error("response pulse too long");
    a_tp_start_cause: assert property ($rose(tp_active) |-> $past(elag_end)
        || $past(elag_end, 2) || $past(pready) || $past(pready, 2))
        else $error("timeout started without cause");
    a_frame_no_pause: assert property (frame_proc && tp_active |=> tp_active)
        else $error("timeout paused by frame");
    a_rtx_after_tp: assert property ($rose(rtx_req) |-> !tp_active)
        else $error("retransmit before expiry");
    a_tp_min_len: assert property ($fell(tp_active) |-> run_r >= 16'd40)
        else $error("timeout run too short");
    c_launch: cover property (tx_go);
    c_retx: cover property ($rose(rtx_req));
    c_frame: cover property (frame_proc && tp_active);
endmodule

bind tp_timing_ctrl tp_timing_monitor tp_timing_monitor_i (.clk, .rst, .pready, .elag_end,
    .nad_slot, .tp_active, .tx_go, .rtx_req, .resp_go, .frame_proc);

/* test/tp_link_model.sv */
`timescale 1ns/1ps
module tp_link_model #(
    parameter int SLOT = 40
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Orders from the bench
    input wire logic       elag_req,
    input wire logic       ack_req,
    input wire logic [3:0] ack_slot,
    // Link events
    output logic           elag_end,
    output logic           ack_rx,
    output logic     [3:0] ack_idx,
    output logic           nad_slot
);
    logic [7:0] cnt_r;
    // Free-running slot grid shared by the net
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r    <= 8'h00;
            nad_slot <= 1'b0;
        end else begin
            cnt_r    <= (cnt_r == 8'(SLOT - 1)) ? 8'h00 : cnt_r + 8'h01;
            nad_slot <= (cnt_r == 8'(SLOT - 1));
        end
    end
    // Index scrambled when idle so a stale slot never looks valid
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elag_end <= 1'b0;
            ack_rx   <= 1'b0;
            ack_idx  <= 4'h0;
        end else begin
            elag_end <= elag_req;
            ack_rx   <= ack_req;
            ack_idx  <= ack_req ? ack_slot : ~ack_idx;
        end
    end
endmodule

/* test/response_timeout_access_timing_tb.sv */
`timescale 1ns/1ps
`include "tp_timing_cfg.svh"
module response_timeout_access_timing_tb;
    // Same values on every station of the subnet
    localparam int EP   = 1;
    localparam int PH   = 1;
    localparam int SS   = 1;
    localparam int EL   = 1;
    localparam int TU   = 2;
    localparam int TO   = 1;
    localparam int DA   = 3;
    localparam int DP   = 4;
    localparam int RHD0 = EP + PH + SS + EL + TU + TO;
    localparam int MXA  = (DA > TU) ? DA : TU;
    localparam int MXP  = (DP > TU) ? DP : TU;
    typedef struct packed {
        logic [11:0] waddr;
        logic [31:0] wdata;
        logic [11:0] raddr;
        logic [31:0] exp;
    } row_t;
    logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        elag_end, ack_rx, nad_slot, tp_active, tx_go, rtx_req, resp_go, frame_proc;
    logic        elag_req, ack_req;
    logic [3:0]  ack_idx, ack_slot;
    int          n_errors, checks_done, n_go, n_resp, n_proc, n;
    row_t        rows [4] = '{
        '{`TP_OFF_DEST, 32'h1, `TP_OFF_RHDVAL, 32'(MXA + TO)},
        '{`TP_OFF_DEST, 32'h2, `TP_OFF_RHDVAL, 32'(RHD0 + MXA + TO)},
        '{`TP_OFF_DEST, 32'h3, `TP_OFF_RHDVAL, 32'(2 * RHD0 + MXA + TO)},
        '{`TP_OFF_DEST, 32'h10, `TP_OFF_RHDVAL, 32'(15 * RHD0 + MXA + TO)}};

    tp_timing_ctrl tp_timing_ctrl_i (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .elag_end, .ack_rx, .ack_idx, .nad_slot,
        .tp_active, .tx_go, .rtx_req, .resp_go, .frame_proc);
    tp_link_model #(.SLOT(40)) tp_link_model_i (.clk, .rst, .elag_req, .ack_req, .ack_slot,
        .elag_end, .ack_rx, .ack_idx, .nad_slot);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tx_go === 1'b1) n_go++;
        if (resp_go === 1'b1) n_resp++;
        if (frame_proc === 1'b1) n_proc++;
    end

    task automatic close_out();
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // Tolerance covers tick alignment of the timer
    task automatic near(input string s, input logic [31:0] e, input logic [31:0] g,
                        input logic [31:0] tol);
        checks_done++;
        if ((g + tol >= e && g <= e + tol) !== 1'b1) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // Bus released for one idle edge so calls never collide
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q       = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Cycles from the call until the timeout ends
    task automatic tp_len(output int c);
        c = 2;
        repeat (2) @(posedge clk);
        while (tp_active === 1'b1 && c < 5000) begin
            @(posedge clk);
            c++;
        end
    endtask
    task automatic elag();
        elag_req <= 1'b1;
        @(posedge clk);
        elag_req <= 1'b0;
    endtask
    task automatic ack(input logic [3:0] s);
        ack_slot <= s;
        ack_req  <= 1'b1;
        @(posedge clk);
        ack_req  <= 1'b0;
    endtask
    // Three destinations, the middle one special address 3
    task automatic arm();
        apb(1'b1, `TP_OFF_EVT, 32'h0);
        apb(1'b1, `TP_OFF_DLIST, 32'h0021);
        apb(1'b1, `TP_OFF_DLIST, 32'h0103);
        apb(1'b1, `TP_OFF_DLIST, 32'h0222);
        apb(1'b1, `TP_OFF_EVT, 32'(`TP_EVT_TX_ACKREQ));
    endtask

    initial begin
        #100_000;
        n_errors++;
        close_out();
    end

    initial begin
        {ce, rst} = 2'b11;
        {psel, penable, pwrite, elag_req, ack_req} = 5'h00;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        ack_slot = 4'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("outputs", 32'h0, {27'h0, tp_active, tx_go, rtx_req, resp_go, frame_proc});
        apb(1'b0, `TP_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h31, q);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped data", 32'h0, q);
        chk("unmapped err", 32'h1, {31'h0, serr});
        apb(1'b1, `TP_OFF_PAR0, {16'(EP), 16'(PH)});
        apb(1'b1, `TP_OFF_PAR1, {16'(SS), 16'(EL)});
        apb(1'b1, `TP_OFF_PAR2, {16'(TU), 16'(TO)});
        apb(1'b1, `TP_OFF_PAR3, {16'(DA), 16'(DP)});
        foreach (rows[k]) begin
            apb(1'b1, rows[k].waddr, rows[k].wdata);
            apb(1'b0, rows[k].raddr, 32'h0);
            chk("hold delay", rows[k].exp, q);
        end
        // Plain send; queued frame and foreign frame arrive mid-timeout
        apb(1'b1, `TP_OFF_EVT, 32'(`TP_EVT_TX_PLAIN));
        fork
            tp_len(n);
            begin
                elag();
                repeat (5) @(posedge clk);
                apb(1'b1, `TP_OFF_EVT, 32'h8);
                apb(1'b1, `TP_OFF_EVT, 32'(`TP_EVT_RX_T124));
            end
        join
        near("plain tp", 32'((MXP + TO) * 10), 32'(n), 32'd12);
        repeat (100) @(posedge clk);
        chk("launch", 32'h1, 32'(n_go));
        chk("frame", 32'h1, 32'(n_proc));
        chk("response", 32'h1, 32'(n_resp));
        // All acknowledgments, one prompt and one slow
        arm();
        fork
            tp_len(n);
            begin
                elag();
                repeat (40) @(posedge clk);
                ack(4'h0);
                repeat (40) @(posedge clk);
                ack(4'h2);
            end
        join
        chk("rtx full", 32'h0, {31'h0, rtx_req});
        // One acknowledgment missing
        arm();
        fork
            tp_len(n);
            begin
                elag();
                repeat (40) @(posedge clk);
                ack(4'h0);
            end
        join
        near("ack tp", 32'((2 * RHD0 + TO + MXA) * 10), 32'(n), 32'd12);
        repeat (3) @(posedge clk);
        chk("rtx", 32'h1, {31'h0, rtx_req});
        // Unexpected acknowledgment loads at once
        apb(1'b1, `TP_OFF_EVT, 32'(`TP_EVT_RX_ACK_UNEX));
        apb(1'b0, `TP_OFF_TPVAL, 32'h0);
        near("unexp tp", 32'(15 * RHD0 + TO + TU), q, 32'd1);
        // Receiver counts address 3; new Type 3 frame replaces the run
        apb(1'b1, `TP_OFF_DLIST, 32'h00010303);
        apb(1'b1, `TP_OFF_EVT, 32'(`TP_EVT_RX_T3));
        fork
            tp_len(n);
            elag();
        join
        near("t3 tp", 32'((3 * RHD0 + TO + MXA) * 10), 32'(n), 32'd12);
        // Acknowledgment while idle starts the long timeout
        apb(1'b1, `TP_OFF_EVT, 32'(`TP_EVT_RX_ACK));
        apb(1'b0, `TP_OFF_TPVAL, 32'h0);
        near("idle ack tp", 32'(15 * RHD0 + TO + TU), q, 32'd1);
        // Reset in mid-run drops the running timeout
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset outputs", 32'h0, {27'h0, tp_active, tx_go, rtx_req, resp_go, frame_proc});
        apb(1'b0, `TP_OFF_TPVAL, 32'h0);
        chk("reset tp", 32'h0, q);
        close_out();
    end
endmodule
